// file: include/ices_pkg.sv
/*
  constants for the i2c channel status and error block
  assumes one 125 mhz clock, same-clock sequencer event pulses
*/
// What this block does
// (R1) eight-bit read-only channel event status register
// (R2) any unmasked set status drives interrupt low
// (R3) status read clears it; only new events set
// (R4) buffer fault cleared only by controller status read
// (R5) bit 7 set after sequence sent and stopped
// (R6) bit 6 set when repeat count reached
// (R7) bit 5 set on write address/data nack
// (R8) bit 4 set on read address nack
// (R9) push-pull channel reads bits 5..1 zero
// (R10) bit 3 set on data line low at start when auto-recover is off
// (R11) bit 1 set on misplaced start or stop
// (R12) bit 0 set when sequence overruns frame time
// (R13) masked overrun: finish sequence, ignore new triggers
// (R14) masked overrun: flag stays, new triggers held off until read
// (R15) unmasked overrun: orderly stop, then interrupt
// (R16) overrun flag set only after bus stop seen
// (R17) misplaced condition interrupts and aborts transaction
// (R18) clock stuck low sets bit 2, aborts
// (R19) auto-recover: abort silently, recover, resume on success
// (R20) auto-recover failure sets data stuck, interrupts, aborts
// (R21) no auto-recover: stuck data interrupts, aborts; host recovers
// (R22) mask bit one suppresses; reset unmasked
package ices_pkg;
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'hc0; // controller level
  localparam logic [7:0] CHAN_STATUS_ADDR = 8'hc1;
  localparam logic [7:0] SUPPRESS_ADDR = 8'hc2;
  localparam logic [7:0] MODE_ADDR = 8'hc6;
  // status bit positions
  localparam int SEQ_DONE_BIT = 7;
  localparam int LOOP_DONE_BIT = 6;
  localparam int WR_NACK_BIT = 5;
  localparam int RD_NACK_BIT = 4;
  localparam int SDA_STUCK_BIT = 3;
  localparam int SCL_STUCK_BIT = 2;
  localparam int MISPLACED_BIT = 1;
  localparam int OVERRUN_BIT = 0;
  // mode register bits
  localparam int AUTO_RECOVER_BIT = 0;
  localparam int BUS_RECOVER_BIT = 1;
  localparam int TIMEOUT_EN_BIT = 2;
  localparam int PUSH_PULL_BIT = 3;
  // controller status bit for buffer fault
  localparam int BUF_FAULT_BIT = 0;
  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SUPPRESS_RESET = 8'h00;
  localparam logic [3:0] MODE_RESET = 4'h0;
  // bits the mask register can suppress; others are non-maskable
  localparam logic [7:0] MASKABLE = 8'hf1;
  // bits absent on the push-pull transmit channel
  localparam logic [7:0] PUSH_PULL_ZERO = 8'h3e;
  // clock line stuck-low timeout
  localparam int CLOCK_MHZ = 125;
  localparam int SCL_TIMEOUT_US = 25000;
  localparam int SCL_TIMEOUT_CYC = SCL_TIMEOUT_US * CLOCK_MHZ;
endpackage

// file: verilog/ices_channel_status.sv
/*
  channel event status, interrupt mask, bus error detection and
  recovery control for one i2c controller channel.
  assumes the sequencer runs on i_clock and gives one-cycle event
  pulses; bus pins arrive asynchronously and are synchronised here.
*/
// Our own choice: the address-and-strobe port.
module ices_channel_status
  import ices_pkg::*;
#(
  parameter int SCL_TIMEOUT = ices_pkg::SCL_TIMEOUT_CYC
)
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // sequencer events, one-cycle pulses on i_clock
  input wire logic i_seq_done,
  input wire logic i_loop_done,
  input wire logic i_wr_nack,
  input wire logic i_rd_nack,
  input wire logic i_sda_low_at_start,
  input wire logic i_recover_ok,
  input wire logic i_recover_fail,
  input wire logic i_frame_overrun,
  input wire logic i_buffer_fault,
  input wire logic i_in_byte, // level: address, data or ack bit active
  // bus pins, asynchronous
  input wire logic i_scl,
  input wire logic i_sda,
  // to the sequencer
  output logic o_abort,
  output logic o_recover_start,
  output logic o_resume,
  output logic o_frame_stop,
  output logic o_hold_triggers,
  output logic o_int_n
);
  import ices_pkg::*;

  localparam logic [21:0] SCL_LIMIT = 22'(SCL_TIMEOUT - 1);
  // assertions sample on the rising clock, quiet during reset
  default clocking assert_clk @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  logic [7:0] channel_event_status;
  logic [7:0] interrupt_suppress_reg;
  logic [3:0] mode;
  logic buffer_fault;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic start_seen;
  logic stop_seen;
  logic [21:0] scl_low_cnt;
  logic scl_stuck;
  logic overrun_pending;
  logic [7:0] set_bits;
  logic [7:0] next_status;
  logic status_read;
  logic ctrl_read;
  logic push_pull_transmit_channel;
  logic auto_recover_enable;
  logic timeout_en;
  logic misplaced_condition_fault;
  logic overrun_suppressed;
  logic [7:0] pending_int;

  assign push_pull_transmit_channel = mode[PUSH_PULL_BIT];
  assign auto_recover_enable = mode[AUTO_RECOVER_BIT];
  assign timeout_en = mode[TIMEOUT_EN_BIT];
  assign overrun_suppressed = interrupt_suppress_reg[OVERRUN_BIT];
  assign status_read = i_rd && (i_addr == CHAN_STATUS_ADDR);
  assign ctrl_read = i_rd && (i_addr == CTRL_STATUS_ADDR);

  // two-flop synchronisers for the bus lines
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end
    else
    begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
    end
  end

  // previous synchronised level for condition detection
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
    end
    else
    begin
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // start: data falls while clock high; stop: data rises
  assign start_seen = scl_prev && scl_sync[1] && sda_prev && !sda_sync[1];
  assign stop_seen = scl_prev && scl_sync[1] && !sda_prev && sda_sync[1];
  assign misplaced_condition_fault =
    i_in_byte && (start_seen || stop_seen); // R11

  // clock line low time counter
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_low_cnt <= 22'h000000;
    end
    else if (scl_sync[1] || !timeout_en)
    begin
      scl_low_cnt <= 22'h000000;
    end
    else if (scl_low_cnt != SCL_LIMIT)
    begin
      scl_low_cnt <= scl_low_cnt + 22'h000001;
    end
  end
  assign scl_stuck = timeout_en && !scl_sync[1] &&
    (scl_low_cnt == SCL_LIMIT - 22'h000001); // R18 one-shot

  // frame overrun waits for the bus stop before it is flagged
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      overrun_pending <= 1'h0;
    end
    else if (i_frame_overrun)
    begin
      overrun_pending <= 1'h1;
    end
    else if (stop_seen)
    begin
      overrun_pending <= 1'h0; // R16
    end
  end
  a_overrun_stop: assert property ( // R16
    $rose(channel_event_status[OVERRUN_BIT]) |-> $past(stop_seen))
    else $error("overrun flagged before stop");

  // event collection into status bits
  always_comb
  begin
    set_bits = 8'h00;
    set_bits[SEQ_DONE_BIT] = i_seq_done; // R5
    set_bits[LOOP_DONE_BIT] = i_loop_done; // R6
    set_bits[WR_NACK_BIT] = i_wr_nack; // R7
    set_bits[RD_NACK_BIT] = i_rd_nack; // R8
    // data stuck: flagged at once without recovery, or on failure
    set_bits[SDA_STUCK_BIT] = (i_sda_low_at_start && !auto_recover_enable)
      || (i_recover_fail && auto_recover_enable); // R10 R20 R21
    set_bits[SCL_STUCK_BIT] = scl_stuck; // R18
    set_bits[MISPLACED_BIT] = misplaced_condition_fault; // R11
    set_bits[OVERRUN_BIT] = overrun_pending && stop_seen; // R12 R16
    if (push_pull_transmit_channel)
    begin
      set_bits = set_bits & ~PUSH_PULL_ZERO; // R9
    end
  end
  a_push_zero: assert property (push_pull_transmit_channel // R9
    && ((channel_event_status & PUSH_PULL_ZERO) == 8'h00)
    |=> (channel_event_status & PUSH_PULL_ZERO) == 8'h00)
    else $error("push-pull channel shows bus error");

  // read clears the status; a new event in the same cycle wins
  always_comb
  begin
    next_status = channel_event_status;
    if (status_read)
    begin
      next_status = 8'h00; // R3
    end
    next_status = next_status | set_bits; // R3
  end

  // channel event status register
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      channel_event_status <= STATUS_RESET;
    end
    else
    begin
      channel_event_status <= next_status; // R1
    end
  end
  a_read_clears: assert property (status_read && !(|set_bits) // R3
    |=> channel_event_status == 8'h00)
    else $error("status not cleared by read");
  a_set_wins: assert property (status_read && i_seq_done // R3
    |=> channel_event_status[SEQ_DONE_BIT])
    else $error("event lost on read");

  // buffer fault, cleared only by the controller status read
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      buffer_fault <= 1'h0;
    end
    else if (i_buffer_fault)
    begin
      buffer_fault <= 1'h1;
    end
    else if (ctrl_read)
    begin
      buffer_fault <= 1'h0; // R4
    end
  end
  a_buf_keep: assert property (buffer_fault && status_read // R4
    |=> buffer_fault)
    else $error("buffer fault cleared by channel read");

  // mask and mode registers
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      interrupt_suppress_reg <= SUPPRESS_RESET; // R22
      mode <= MODE_RESET;
    end
    else if (i_wr && (i_addr == SUPPRESS_ADDR))
    begin
      interrupt_suppress_reg <= i_wdata & MASKABLE; // R22
    end
    else if (i_wr && (i_addr == MODE_ADDR))
    begin
      mode <= {i_wdata[PUSH_PULL_BIT], i_wdata[TIMEOUT_EN_BIT],
        1'h0, i_wdata[AUTO_RECOVER_BIT]};
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
    end
    else if (!i_rd)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_addr == CHAN_STATUS_ADDR)
    begin
      o_rdata <= channel_event_status;
    end
    else if (i_addr == SUPPRESS_ADDR)
    begin
      o_rdata <= interrupt_suppress_reg;
    end
    else if (i_addr == MODE_ADDR)
    begin
      o_rdata <= {4'h0, mode};
    end
    else if (i_addr == CTRL_STATUS_ADDR)
    begin
      o_rdata <= {7'h00, buffer_fault};
    end
    else
    begin
      o_rdata <= 8'h00; // unmapped
    end
  end

  // interrupt: unmasked status, non-maskable errors, buffer fault
  assign pending_int = channel_event_status & ~interrupt_suppress_reg;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_int_n <= 1'h1;
    end
    else
    begin
      o_int_n <= !((|pending_int) || buffer_fault); // R2 R22
    end
  end
  a_int_follows: assert property ($rose(|pending_int) |=> !o_int_n) // R2
    else $error("interrupt not asserted");
  a_mask_holds: assert property (!(|pending_int) && !buffer_fault // R22
    |=> o_int_n)
    else $error("masked status raised interrupt");

  // transaction abort on bus errors and stuck data
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_abort <= 1'h0;
    end
    else
    begin
      o_abort <= set_bits[MISPLACED_BIT] || set_bits[SCL_STUCK_BIT]
        || set_bits[SDA_STUCK_BIT]
        || (i_sda_low_at_start && !push_pull_transmit_channel);
        // R17 R18 R19 R20 R21
    end
  end
  a_misplaced_abort: assert property ( // R11 R17
    misplaced_condition_fault && !push_pull_transmit_channel
    |=> o_abort && channel_event_status[MISPLACED_BIT])
    else $error("misplaced condition not handled");

  // recovery start: automatic at stuck start, or host request
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_recover_start <= 1'h0;
      o_resume <= 1'h0;
    end
    else
    begin
      o_recover_start <= (i_sda_low_at_start && auto_recover_enable)
        || (i_wr && (i_addr == MODE_ADDR)
        && i_wdata[BUS_RECOVER_BIT]); // R19 R21
      o_resume <= i_recover_ok && auto_recover_enable; // R19
    end
  end
  a_auto_silent: assert property ( // R19
    i_sda_low_at_start && auto_recover_enable && !i_recover_fail
    |=> o_recover_start && !$rose(channel_event_status[SDA_STUCK_BIT]))
    else $error("auto-recovery misbehaved");

  // unmasked overrun asks the sequencer for an orderly stop
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_frame_stop <= 1'h0;
    end
    else
    begin
      o_frame_stop <= i_frame_overrun && !overrun_suppressed; // R15
    end
  end
  a_overrun_stop_req: assert property ( // R15
    i_frame_overrun && !overrun_suppressed |=> o_frame_stop)
    else $error("no orderly stop on overrun");

  // masked overrun: ignore triggers mid-sequence until status read
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_hold_triggers <= 1'h0;
    end
    else
    begin
      o_hold_triggers <= overrun_suppressed &&
        (overrun_pending || next_status[OVERRUN_BIT]); // R13 R14
    end
  end

endmodule

// file: tb/ices_bus_model.sv
/*
  far-side slave model: open-drain scl and sda with pull-ups.
  assumes the bench asks for one frame at a time and may hold scl low.
*/
module ices_bus_model (
  input wire logic i_frame,
  input wire logic i_hold_scl,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_run;
  // a stuck slave pulls the clock low against the pull-up
  assign o_scl = scl_run & ~i_hold_scl;
  initial
  begin
    scl_run = 1'b1;
    o_sda = 1'b1;
  end
  // two clock bits, then a start and a stop inside clock-high phases
  always
  begin
    wait (i_frame);
    repeat (2)
    begin
      #62.5 scl_run = 1'b0;
      #62.5 scl_run = 1'b1;
    end
    #30 o_sda = 1'b0;
    #32.5 scl_run = 1'b0;
    #62.5 scl_run = 1'b1;
    #30 o_sda = 1'b1;
    wait (!i_frame);
  end
endmodule

// file: tb/ices_channel_status_tb.sv
/*
  self-checking bench for the channel status block.
  assumes the sequencer events are one-cycle pulses and a short timeout.
*/
module ices_channel_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ices_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rds = 1'b0, in_byte = 1'b0, frame = 1'b0, hold = 1'b0;
  logic [8:0] ev = 9'h000;
  logic scl, sda, abort, rstart, resume, fstop, htrig, int_n;
  int mismatches = 0, n_compared = 0;
  int n_ab = 0, n_rs = 0, n_res = 0, n_fs = 0, a, b;

  always #4 i_clock = ~i_clock;
  // count the one-cycle pulses of the sequencer controls
  always @(posedge i_clock)
  begin
    n_ab += int'(abort === 1'b1);
    n_rs += int'(rstart === 1'b1);
    n_res += int'(resume === 1'b1);
    n_fs += int'(fstop === 1'b1);
  end

  ices_channel_status #(.SCL_TIMEOUT(50)) ices_channel_status_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rds), .o_rdata(rdata),
    .i_seq_done(ev[0]), .i_loop_done(ev[1]), .i_wr_nack(ev[2]),
    .i_rd_nack(ev[3]), .i_sda_low_at_start(ev[4]),
    .i_recover_ok(ev[5]), .i_recover_fail(ev[6]),
    .i_frame_overrun(ev[7]), .i_buffer_fault(ev[8]),
    .i_in_byte(in_byte), .i_scl(scl), .i_sda(sda), .o_abort(abort),
    .o_recover_start(rstart), .o_resume(resume),
    .o_frame_stop(fstop), .o_hold_triggers(htrig), .o_int_n(int_n)
  );
  ices_bus_model ices_bus_model_i (
    .i_frame(frame), .i_hold_scl(hold), .o_scl(scl), .o_sda(sda)
  );

  task check(input string n, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task wr8(input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_clock);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd8(input logic [7:0] ad, input logic [7:0] e, input string n);
    @(posedge i_clock);
    addr <= ad;
    rds <= 1'b1;
    @(posedge i_clock);
    rds <= 1'b0;
    #1 check(n, rdata, e);
  endtask

  task fire(input int k);
    @(posedge i_clock);
    ev[k] <= 1'b1;
    @(posedge i_clock);
    ev <= 9'h000;
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  task run_frame;
    @(posedge i_clock);
    frame <= 1'b1;
    repeat (60) @(posedge i_clock);
    frame <= 1'b0;
    repeat (10) @(posedge i_clock);
    #1;
  endtask

  task t_reset;
    rd8(CHAN_STATUS_ADDR, STATUS_RESET, "st");
    rd8(SUPPRESS_ADDR, SUPPRESS_RESET, "msk");
    rd8(8'hff, 8'h00, "unmapped");
    check("int", int_n, 8'h01);
    wr8(CHAN_STATUS_ADDR, 8'hff);
    rd8(CHAN_STATUS_ADDR, 8'h00, "ro");
    $display("done reset");
  endtask

  task t_events;
    for (int k = 0; k < 4; k++)
    begin
      fire(k);
      check("int", int_n, 8'h00);
      rd8(CHAN_STATUS_ADDR, 8'h80 >> k, "st");
      repeat (2) @(posedge i_clock);
      #1 check("int", int_n, 8'h01);
      rd8(CHAN_STATUS_ADDR, 8'h00, "st");
    end
    $display("done events");
  endtask

  task t_mask;
    wr8(SUPPRESS_ADDR, 8'hff);
    rd8(SUPPRESS_ADDR, MASKABLE, "msk");
    fire(0);
    check("int", int_n, 8'h01);
    rd8(CHAN_STATUS_ADDR, 8'h80, "st");
    a = n_ab;
    fire(4);
    check("int", int_n, 8'h00);
    check("abt", n_ab - a, 8'h01);
    rd8(CHAN_STATUS_ADDR, 8'h08, "st");
    wr8(SUPPRESS_ADDR, 8'h00);
    $display("done mask");
  endtask

  task t_recover;
    wr8(MODE_ADDR, 8'h01);
    a = n_ab;
    b = n_rs;
    fire(4);
    check("abt", n_ab - a, 8'h01);
    check("rec", n_rs - b, 8'h01);
    check("int", int_n, 8'h01);
    rd8(CHAN_STATUS_ADDR, 8'h00, "st");
    a = n_res;
    fire(5);
    check("res", n_res - a, 8'h01);
    fire(4);
    a = n_ab;
    fire(6);
    check("abt", n_ab - a, 8'h01);
    check("int", int_n, 8'h00);
    rd8(CHAN_STATUS_ADDR, 8'h08, "st");
    b = n_rs;
    wr8(MODE_ADDR, 8'h02);
    repeat (2) @(posedge i_clock);
    #1 check("rec", n_rs - b, 8'h01);
    wr8(MODE_ADDR, 8'h00);
    $display("done recover");
  endtask

  task t_pushpull;
    wr8(MODE_ADDR, 8'h08);
    for (int k = 2; k < 5; k++)
      fire(k);
    fire(0);
    rd8(CHAN_STATUS_ADDR, 8'h80, "st");
    wr8(MODE_ADDR, 8'h00);
    rd8(CHAN_STATUS_ADDR, 8'h00, "st");
    $display("done push-pull");
  endtask

  task t_overrun;
    a = n_fs;
    fire(7);
    check("fstop", n_fs - a, 8'h01);
    check("int", int_n, 8'h01);
    rd8(CHAN_STATUS_ADDR, 8'h00, "st");
    run_frame();
    check("int", int_n, 8'h00);
    rd8(CHAN_STATUS_ADDR, 8'h01, "st");
    wr8(SUPPRESS_ADDR, 8'h01);
    a = n_fs;
    fire(7);
    check("fstop", n_fs - a, 8'h00);
    check("hold", htrig, 8'h01);
    run_frame();
    check("int", int_n, 8'h01);
    check("hold", htrig, 8'h01);
    rd8(CHAN_STATUS_ADDR, 8'h01, "st");
    repeat (2) @(posedge i_clock);
    #1 check("hold", htrig, 8'h00);
    wr8(SUPPRESS_ADDR, 8'h00);
    $display("done overrun");
  endtask

  task t_bus;
    wr8(SUPPRESS_ADDR, 8'hff);
    in_byte <= 1'b1;
    a = n_ab;
    run_frame();
    @(posedge i_clock);
    in_byte <= 1'b0;
    check("abt", n_ab != a, 8'h01);
    check("int", int_n, 8'h00);
    rd8(CHAN_STATUS_ADDR, 8'h02, "st");
    wr8(MODE_ADDR, 8'h04);
    a = n_ab;
    hold <= 1'b1;
    repeat (80) @(posedge i_clock);
    #1 check("abt", n_ab - a, 8'h01);
    check("int", int_n, 8'h00);
    @(posedge i_clock);
    hold <= 1'b0;
    rd8(CHAN_STATUS_ADDR, 8'h04, "st");
    wr8(MODE_ADDR, 8'h00);
    wr8(SUPPRESS_ADDR, 8'h00);
    $display("done bus errors");
  endtask

  task t_buffer;
    fire(8);
    check("int", int_n, 8'h00);
    rd8(CHAN_STATUS_ADDR, 8'h00, "st");
    check("int", int_n, 8'h00);
    rd8(CTRL_STATUS_ADDR, 8'h01, "ctl");
    rd8(CTRL_STATUS_ADDR, 8'h00, "ctl");
    check("int", int_n, 8'h01);
    $display("done buffer");
  endtask

  // reset, then each scenario in turn
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_events();
    t_mask();
    t_recover();
    t_pushpull();
    t_overrun();
    t_bus();
    t_buffer();
    print_verdict();
  end
endmodule
